// ---- rtl/boost_fault_params.svh ----
// Constants for the boost fault-response block: register offsets,
// field positions, reset values and timing counts.
// Assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus.
// Summary of operation
// R1 - HS overload sets overload flag; converter keeps running
// R2 - Short: LS off now, HS on until current below overload, set flag
// R3 - Short: clear enable, SAFE, count error, pull interrupt low
// R4 - UV reset select 1b: RESET once output below UV after shutdown
// R5 - Reverse current sets flag; persisting over 20 us turns converter off
// R6 - Reverse-current shutdown responds like a short as in R3; no HS force-on, reverse flag not short flag
// R7 - Ignore reverse current from enable until output above UV
// R8 - Re-enable during current limit: switch off again, count error
// R9 - Thermal warning sets flag; interrupt only if pin high and enabled
// R10 - Thermal shutdown: SAFE, off, clear enable, flag, count, interrupt
// R11 - After thermal shutdown stay off until temperature below warn minus hysteresis
// R12 - Controller clears write lock and sets enable to restart after overtemp
// R13 - Overvoltage: SAFE, off, clear enable, flag, count, interrupt
// R14 - Overvoltage persisting off-delay after disable: OFF, latch flag
// R15 - Controller re-enables after overvoltage only below restart level
// R16 - Gate supply undervoltage: all regulators off, OFF, latch flag
// R17 - Gate supply overvoltage: all regulators off, OFF, latch flag
// R18 - Gate supply from LDO below 4.7 V, else pass switch from external
// R19 - Boost enable is set at power-up; controller may clear it
// R20 - Error counter at power-down threshold: enter OFF
// R21 - Fault flags stay set until the controller clears them
`ifndef BOOST_FAULT_PARAMS_SVH
`define BOOST_FAULT_PARAMS_SVH

`define OFS_STATUS 12'h000
`define OFS_CTRL 12'h004
`define OFS_STATE 12'h008
`define OFS_LATCH 12'h00c

// Status bits (write one to clear)
`define ST_OVERLOAD 0
`define ST_SHORT 1
`define ST_REVERSE 2
`define ST_TWARN 3
`define ST_TSHUT 4
`define ST_OVP 5
`define ST_WIDTH 6

// Control bits
`define CT_BOOST_EN 0
`define CT_UV_RST_SEL 1
`define CT_TWARN_IRQ_EN 2
`define CT_LOCK 3
`define CT_POWERDOWN_THRESHOLD_LSB 4
`define CT_POWERDOWN_THRESHOLD_MSB 7
`define CTRL_RESET 8'hf1

// Supply fault latch bits
`define LT_OVP 0
`define LT_GATE_SUPPLY_UNDERVOLT_FLAG 1
`define LT_GATE_SUPPLY_OVERVOLT_FLAG 2

`define REV_LIMIT_NS 20000
`define CLK_PERIOD_NS 25
`define REV_LIMIT_CYC (`REV_LIMIT_NS / `CLK_PERIOD_NS)
`define OVP_OFF_CYC 200

`endif

// ---- rtl/boost_fault_pkg.sv ----
// Types for the boost fault-response block.
// Assumes the constants header is available to every user.
package boost_fault_pkg;
    typedef enum logic [1:0] {ST_ACTIVE, ST_SAFE, ST_RESET, ST_OFF}
        dev_state_t;

    typedef struct packed {
        logic hs_overload;
        logic ls_short;
        logic hs_reverse;
        logic out_uv;
        logic out_ovp;
        logic temp_warn;
        logic temp_shut;
        logic temp_cool;
        logic gate_supply_undervolt_flag;
        logic gate_supply_overvolt_flag;
        logic ext_above;
    } sense_t;

    typedef struct packed {
        logic ls_gate_en;
        logic hs_force_on;
        logic conv_on;
        logic regs_off;
        logic ldo_on;
        logic pass_on;
    } drive_t;
endpackage : boost_fault_pkg

// ---- rtl/boost_fault_response.sv ----
// Fault reaction logic for the step-up converter and the gate supply.
// Analog comparators arrive as synchronous levels in sense; registers sit
// behind an AXI4-Lite slave answering two cycles after both halves arrive.
`timescale 1ns/1ps
`include "boost_fault_params.svh"

module boost_fault_response #(
    parameter int REV_CYC = `REV_LIMIT_CYC,
    parameter int OVP_OFF = `OVP_OFF_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire boost_fault_pkg::sense_t sense,
    output boost_fault_pkg::drive_t drive,
    output boost_fault_pkg::dev_state_t dev_state,
    output logic fault_interrupt_pin_o,
    output logic fault_interrupt_pin_oe
);
    import boost_fault_pkg::*;

    logic [`ST_WIDTH-1:0] boost_fault_status_1;
    logic [7:0] power_control_register;
    logic [2:0] supply_fault_latch;
    logic [3:0] device_error_counter;
    logic irq_low;
    logic shut_pend;
    logic uv_seen;
    logic rev_mask;
    logic hot_lock;
    logic [$clog2(REV_CYC+1)-1:0] rev_cnt;
    logic [$clog2(OVP_OFF+1)-1:0] ovp_cnt;
    logic en_prev;
    logic hs_hold;

    // AXI write channel state
    logic aw_held, w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic [`ST_WIDTH-1:0] clr_mask;
    logic ctrl_wr;
    logic [7:0] ctrl_wval;

    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign ctrl_wr = wr_fire && aw_addr == `OFS_CTRL && w_strb[0];
    assign ctrl_wval = w_data[7:0];
    assign clr_mask = (wr_fire && aw_addr == `OFS_STATUS && w_strb[0])
        ? w_data[`ST_WIDTH-1:0] : '0;

    wire boost_en = power_control_register[`CT_BOOST_EN];
    wire [3:0] powerdown_threshold =
        power_control_register[`CT_POWERDOWN_THRESHOLD_MSB:`CT_POWERDOWN_THRESHOLD_LSB];
    wire conv_run = boost_en && !hot_lock && dev_state != ST_OFF;
    wire rev_live = sense.hs_reverse && !rev_mask;
    wire rev_trip = rev_live && rev_cnt == REV_CYC[$bits(rev_cnt)-1:0];
    wire cur_trip = conv_run && (sense.ls_short || rev_trip);
    wire enable_edge = boost_en && !en_prev;
    wire relimit = enable_edge && (sense.ls_short || sense.hs_overload);
    wire tshut = conv_run && sense.temp_shut;
    wire ovp_trip = conv_run && sense.out_ovp;
    wire shutdown = cur_trip || tshut || ovp_trip;
    wire ovp_late = !conv_run && ovp_cnt == OVP_OFF[$bits(ovp_cnt)-1:0];
    wire gate_driver_supply_bad = sense.gate_supply_undervolt_flag || sense.gate_supply_overvolt_flag;
    wire err_step = shutdown || relimit;
    wire [3:0] next_err = device_error_counter + 4'h1;
    wire [`ST_WIDTH-1:0] next_status = (boost_fault_status_1 & ~clr_mask)
        | {ovp_trip, tshut, // R13 R10
           sense.temp_warn, // R9
           rev_live, // R5
           hs_hold && !sense.hs_overload, // R2
           conv_run && sense.hs_overload}; // R1

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[11:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
        end
    end

    // Reads answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                case ({s_axi_araddr[11:2], 2'b00})
                    `OFS_STATUS: s_axi_rdata <=
                        {{(32-`ST_WIDTH){1'b0}}, boost_fault_status_1};
                    `OFS_CTRL: s_axi_rdata <= {24'h0, power_control_register};
                    `OFS_STATE: s_axi_rdata <= {24'h0, device_error_counter,
                        1'b0, irq_low, dev_state};
                    `OFS_LATCH: s_axi_rdata <= {29'h0, supply_fault_latch};
                    default: s_axi_rdata <= 32'h0000_0000;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
    assign s_axi_bresp = 2'b00;
    assign s_axi_rresp = 2'b00;

    // Sticky flags: hardware set wins over a write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            boost_fault_status_1 <= '0;
        end else begin
            boost_fault_status_1 <= next_status; // R21
        end
    end

    // Enable bit, set at power-up; while locked, writes that keep the lock bit set are refused
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_control_register <= `CTRL_RESET; // R19
        end else if (shutdown || relimit) begin
            power_control_register[`CT_BOOST_EN] <= 1'b0; // R3 R6 R8 R10 R13
        end else if (ctrl_wr) begin
            if (!power_control_register[`CT_LOCK] || !ctrl_wval[`CT_LOCK])
                power_control_register <= ctrl_wval; // R12
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_prev <= 1'b1;
        end else begin
            en_prev <= boost_en;
        end
    end

    // Short flag waits until the forced high-side path has drained the coil
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hs_hold <= 1'b0;
        end else if (conv_run && sense.ls_short) begin
            hs_hold <= 1'b1; // R2
        end else if (!sense.hs_overload) begin
            hs_hold <= 1'b0; // R2
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rev_mask <= 1'b1;
        end else if (enable_edge) begin
            rev_mask <= 1'b1; // R7
        end else if (!sense.out_uv) begin
            rev_mask <= 1'b0; // R7
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rev_cnt <= '0;
        end else if (!rev_live || rev_trip) begin
            rev_cnt <= '0;
        end else begin
            rev_cnt <= rev_cnt + 1'b1; // R5
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hot_lock <= 1'b0;
        end else if (tshut) begin
            hot_lock <= 1'b1; // R11
        end else if (sense.temp_cool) begin
            hot_lock <= 1'b0; // R11
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovp_cnt <= '0;
        end else if (conv_run || !sense.out_ovp) begin
            ovp_cnt <= '0;
        end else if (!ovp_late) begin
            ovp_cnt <= ovp_cnt + 1'b1; // R14
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            device_error_counter <= 4'h0;
        end else if (err_step && device_error_counter != 4'hf) begin
            device_error_counter <= next_err; // R3 R8 R10 R13
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            supply_fault_latch <= 3'b000;
        end else begin
            if (ovp_late && sense.out_ovp)
                supply_fault_latch[`LT_OVP] <= 1'b1; // R14
            if (sense.gate_supply_undervolt_flag)
                supply_fault_latch[`LT_GATE_SUPPLY_UNDERVOLT_FLAG] <= 1'b1; // R16
            if (sense.gate_supply_overvolt_flag)
                supply_fault_latch[`LT_GATE_SUPPLY_OVERVOLT_FLAG] <= 1'b1; // R17
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shut_pend <= 1'b0;
            uv_seen <= 1'b0;
        end else begin
            if (shutdown)
                shut_pend <= 1'b1;
            else if (dev_state == ST_RESET || dev_state == ST_ACTIVE)
                shut_pend <= 1'b0;
            uv_seen <= sense.out_uv;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dev_state <= ST_ACTIVE;
        end else begin
            case (dev_state)
                ST_OFF: dev_state <= ST_OFF;
                default: begin
                    if (gate_driver_supply_bad || ovp_late) begin
                        dev_state <= ST_OFF; // R14 R16 R17
                    end else if (err_step && next_err >= powerdown_threshold) begin
                        dev_state <= ST_OFF; // R20
                    end else if (shutdown) begin
                        dev_state <= ST_SAFE; // R3 R6 R10 R13
                    end else if (shut_pend && uv_seen &&
                        power_control_register[`CT_UV_RST_SEL]) begin
                        dev_state <= ST_RESET; // R4
                    end else if (dev_state == ST_RESET) begin
                        dev_state <= ST_ACTIVE;
                    end
                end
            endcase
        end
    end

    // Interrupt low until the controller clears every raised status flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_low <= 1'b0;
        end else if (shutdown || relimit) begin
            irq_low <= 1'b1; // R3 R6 R10 R13
        end else if (sense.temp_warn && !irq_low &&
            power_control_register[`CT_TWARN_IRQ_EN]) begin
            irq_low <= 1'b1; // R9
        end else if (next_status == '0) begin
            irq_low <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive <= '0;
            fault_interrupt_pin_o <= 1'b0;
            fault_interrupt_pin_oe <= 1'b0;
        end else begin
            drive.ls_gate_en <= conv_run && !sense.ls_short && !shutdown; // R2
            drive.hs_force_on <= (sense.ls_short || hs_hold) &&
                sense.hs_overload; // R2
            drive.conv_on <= conv_run && !err_step && !gate_driver_supply_bad; // R1 R8
            drive.regs_off <= gate_driver_supply_bad || dev_state == ST_OFF; // R16 R17
            drive.ldo_on <= !sense.ext_above; // R18
            drive.pass_on <= sense.ext_above; // R18
            fault_interrupt_pin_o <= 1'b0;
            fault_interrupt_pin_oe <= irq_low;
        end
    end

    a_short_clears_en: assert property (@(posedge aclk) disable iff (!aresetn)
        cur_trip |=> !boost_en) else $error("enable not cleared"); // R3
    a_short_safe: assert property (@(posedge aclk) disable iff (!aresetn)
        shutdown && !gate_driver_supply_bad && !ovp_late && !(next_err >= powerdown_threshold)
        |=> dev_state == ST_SAFE) else $error("no SAFE entry"); // R13
    a_err_count: assert property (@(posedge aclk) disable iff (!aresetn)
        err_step && device_error_counter != 4'hf
        |=> device_error_counter == $past(device_error_counter) + 4'h1)
        else $error("error counter not stepped"); // R10
    a_irq_after_fault: assert property (@(posedge aclk)
        disable iff (!aresetn) shutdown |=> ##1 fault_interrupt_pin_oe)
        else $error("interrupt not driven"); // R6
    a_rev_mask: assert property (@(posedge aclk) disable iff (!aresetn)
        rev_mask && !boost_fault_status_1[`ST_REVERSE]
        |=> !boost_fault_status_1[`ST_REVERSE])
        else $error("masked reverse flagged"); // R7
    a_hot_lock: assert property (@(posedge aclk) disable iff (!aresetn)
        hot_lock && !sense.temp_cool |=> ##1 !drive.conv_on)
        else $error("converter on while hot"); // R11
    a_gate_driver_supply_off: assert property (@(posedge aclk) disable iff (!aresetn)
        sense.gate_supply_undervolt_flag |=> dev_state == ST_OFF
            && supply_fault_latch[`LT_GATE_SUPPLY_UNDERVOLT_FLAG]) else $error("no OFF"); // R16
    a_gate_supply_overvolt_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        sense.gate_supply_overvolt_flag |=> ##1 drive.regs_off)
        else $error("regulators left on"); // R17
    a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        boost_fault_status_1[`ST_OVERLOAD] && clr_mask == '0
        |=> boost_fault_status_1[`ST_OVERLOAD])
        else $error("flag lost"); // R21
    a_gate_path: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> drive.ldo_on != drive.pass_on)
        else $error("supply path"); // R18

    c_short: cover property (@(posedge aclk) cur_trip);
    c_reset: cover property (@(posedge aclk) dev_state == ST_RESET);
    c_off: cover property (@(posedge aclk) dev_state == ST_OFF);
endmodule : boost_fault_response

// ---- test/irq_line_model.sv ----
// Controller side of the open-drain fault interrupt line, with its pull-up.
// Assumes the block's pin output and enable feed it directly.
`timescale 1ns/1ps

module irq_line_model (
    input wire logic pin_o,
    input wire logic pin_oe,
    output logic line
);
    // A released line rises through the pull-up; it never keeps the old level
    assign line = pin_oe ? pin_o : 1'b1;
endmodule : irq_line_model

// ---- test/tb_top.sv ----
// Self-checking bench for the boost fault-response block.
// Assumes the design and the interrupt line model are compiled first.
`timescale 1ns/1ps
`include "boost_fault_params.svh"

module tb_top;
    import boost_fault_pkg::*;
    localparam sense_t IDLE = '{temp_cool: 1'b1, default: 1'b0};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq_o, irq_oe, irq_line;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    sense_t sense = IDLE;
    drive_t drive;
    dev_state_t dev_state;
    int errors = 0;
    int cmp_count = 0;

    always #12.5 aclk = ~aclk;

    // Short counts keep the persistence and off-delay tests brief
    boost_fault_response #(.REV_CYC(4), .OVP_OFF(4)) i_boost_fault_response (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sense(sense),
        .drive(drive), .dev_state(dev_state),
        .fault_interrupt_pin_o(irq_o), .fault_interrupt_pin_oe(irq_oe));

    irq_line_model i_irq_line_model (
        .pin_o(irq_o), .pin_oe(irq_oe), .line(irq_line));

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask : tick

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        bit ad;
        bit wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (!ad && awready === 1'b1) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wd && wready === 1'b1) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        chk("bresp", {30'h0, bresp}, 32'h0);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(posedge aclk);
        while (arready !== 1'b1) @(posedge aclk);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        v = rdata;
        chk("rresp", {30'h0, rresp}, 32'h0);
        rready <= 1'b0;
    endtask : rd

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp,
                        input string what);
        logic [31:0] v;
        rd(a, v);
        chk(what, v, exp);
    endtask : rchk

    task automatic cnt_chk(input logic [3:0] exp);
        logic [31:0] v;
        rd(`OFS_STATE, v);
        chk("error counter", {28'h0, v[7:4]}, {28'h0, exp});
    endtask : cnt_chk

    task automatic wait_state(input dev_state_t s);
        int n;
        n = 0;
        while (dev_state !== s && n < 50) begin
            @(posedge aclk);
            n++;
        end
        chk("state", dev_state, s);
    endtask : wait_state

    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        sense <= IDLE;
        tick(3);
        aresetn <= 1'b1;
    endtask : do_reset

    // Output discharge takes the block through RESET back to ACTIVE
    task automatic recover();
        @(posedge aclk);
        sense.out_uv <= 1'b1;
        wait_state(ST_ACTIVE);
        sense.out_uv <= 1'b0;
        wr(`OFS_STATUS, 32'h3f);
    endtask : recover

    task automatic done(input string n);
        $display("test %s finished, mismatches so far %0d", n, errors);
    endtask : done

    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        print_verdict();
    end

    initial begin
        do_reset();
        rchk(`OFS_CTRL, 32'hf1, "ctrl");
        rchk(`OFS_STATUS, 32'h0, "status");
        rchk(`OFS_LATCH, 32'h0, "latch");
        rchk(12'h010, 32'h0, "unmapped");
        chk("ldo_on", drive.ldo_on, 1'b1);
        sense.ext_above <= 1'b1;
        tick(3);
        chk("pass_on", drive.pass_on, 1'b1);
        chk("ldo_on", drive.ldo_on, 1'b0);
        wr(`OFS_CTRL, 32'hf3);
        done("reset and supply path");
        sense.hs_overload <= 1'b1;
        tick(3);
        chk("state", dev_state, ST_ACTIVE);
        chk("conv_on", drive.conv_on, 1'b1);
        sense.hs_overload <= 1'b0;
        rchk(`OFS_STATUS, 32'h01, "overload kept");
        wr(`OFS_STATUS, 32'h01);
        rchk(`OFS_STATUS, 32'h0, "overload cleared");
        done("overload");
        sense.hs_overload <= 1'b1;
        sense.ls_short <= 1'b1;
        tick(3);
        chk("ls_gate_en", drive.ls_gate_en, 1'b0);
        chk("hs_force_on", drive.hs_force_on, 1'b1);
        sense.hs_overload <= 1'b0;
        sense.ls_short <= 1'b0;
        wait_state(ST_SAFE);
        tick(2);
        chk("hs_force_on", drive.hs_force_on, 1'b0);
        rchk(`OFS_STATUS, 32'h03, "short flag");
        rchk(`OFS_CTRL, 32'hf2, "enable cleared");
        cnt_chk(4'h1);
        chk("irq line", irq_line, 1'b0);
        sense.hs_overload <= 1'b1;
        wr(`OFS_CTRL, 32'hf3);
        rchk(`OFS_CTRL, 32'hf2, "enable refused");
        sense.hs_overload <= 1'b0;
        cnt_chk(4'h2);
        sense.out_uv <= 1'b1;
        wait_state(ST_RESET);
        recover();
        done("short");
        sense.out_uv <= 1'b1;
        wr(`OFS_CTRL, 32'hf3);
        sense.hs_reverse <= 1'b1;
        tick(8);
        chk("state", dev_state, ST_ACTIVE);
        rchk(`OFS_STATUS, 32'h0, "masked reverse");
        sense.hs_reverse <= 1'b0;
        sense.out_uv <= 1'b0;
        tick(2);
        sense.hs_reverse <= 1'b1;
        tick(2);
        sense.hs_reverse <= 1'b0;
        tick(3);
        chk("state", dev_state, ST_ACTIVE);
        rchk(`OFS_STATUS, 32'h04, "reverse flag");
        sense.hs_reverse <= 1'b1;
        wait_state(ST_SAFE);
        sense.hs_reverse <= 1'b0;
        rchk(`OFS_CTRL, 32'hf2, "enable cleared");
        cnt_chk(4'h3);
        chk("irq line", irq_line, 1'b0);
        recover();
        done("reverse current");
        sense.temp_warn <= 1'b1;
        tick(3);
        chk("irq line", irq_line, 1'b1);
        sense.temp_warn <= 1'b0;
        rchk(`OFS_STATUS, 32'h08, "warn flag");
        wr(`OFS_STATUS, 32'h08);
        wr(`OFS_CTRL, 32'hf7);
        sense.temp_warn <= 1'b1;
        tick(3);
        chk("irq line", irq_line, 1'b0);
        sense.temp_warn <= 1'b0;
        wr(`OFS_STATUS, 32'h08);
        tick(2);
        chk("irq line", irq_line, 1'b1);
        done("thermal warning");
        sense.temp_shut <= 1'b1;
        sense.temp_cool <= 1'b0;
        wait_state(ST_SAFE);
        chk("conv_on", drive.conv_on, 1'b0);
        sense.temp_shut <= 1'b0;
        rchk(`OFS_STATUS, 32'h10, "shutdown flag");
        rchk(`OFS_CTRL, 32'hf6, "enable cleared");
        cnt_chk(4'h4);
        chk("irq line", irq_line, 1'b0);
        recover();
        wr(`OFS_CTRL, 32'hf7);
        tick(3);
        chk("conv_on hot", drive.conv_on, 1'b0);
        sense.temp_cool <= 1'b1;
        tick(3);
        chk("conv_on cool", drive.conv_on, 1'b1);
        done("thermal shutdown");
        sense.out_ovp <= 1'b1;
        wait_state(ST_SAFE);
        chk("conv_on", drive.conv_on, 1'b0);
        rchk(`OFS_STATUS, 32'h20, "ovp flag");
        rchk(`OFS_CTRL, 32'hf6, "enable cleared");
        cnt_chk(4'h5);
        chk("irq line", irq_line, 1'b0);
        wait_state(ST_OFF);
        sense.out_ovp <= 1'b0;
        rchk(`OFS_LATCH, 32'h01, "ovp latch");
        chk("state held", dev_state, ST_OFF);
        done("overvoltage");
        for (int i = 0; i < 2; i++) begin
            do_reset();
            sense.gate_supply_undervolt_flag <= (i == 0);
            sense.gate_supply_overvolt_flag <= (i == 1);
            wait_state(ST_OFF);
            chk("regs_off", drive.regs_off, 1'b1);
            rchk(`OFS_LATCH, 32'h2 << i, "gate supply latch");
        end
        done("gate supply");
        do_reset();
        wr(`OFS_CTRL, 32'h23);
        for (int k = 0; k < 2; k++) begin
            sense.temp_shut <= 1'b1;
            tick(3);
            sense.temp_shut <= 1'b0;
            wait_state(k ? ST_OFF : ST_SAFE);
            if (k == 0) begin
                recover();
                wr(`OFS_CTRL, 32'h23);
            end
        end
        cnt_chk(4'h2);
        done("powerdown threshold");
        print_verdict();
    end
endmodule : tb_top
